// *** core/tpt_pkg.sv ***
// Package for the triggered pulse timer: register map, field codes, timing constants.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package tpt_pkg;
  // Register byte offsets
  localparam logic [7:0] TPT_CTRL_OFS = 8'h00;
  localparam logic [7:0] TPT_PULSE_OFS = 8'h04;
  localparam logic [7:0] TPT_WAIT_OFS = 8'h08;
  localparam logic [7:0] TPT_CMD_OFS = 8'h0c;
  localparam logic [7:0] TPT_STAT_OFS = 8'h10;
  // Control field positions
  localparam int TPT_ORIGIN_POS = 0;
  localparam int TPT_COND_POS = 4;
  localparam int TPT_DRIVE_POS = 8;
  localparam int TPT_FLIP_POS = 12;
  // Reset values
  localparam logic [31:0] TPT_PULSE_RST = 32'h0000_0001;
  localparam logic [31:0] TPT_WAIT_RST = 32'h0000_0000;
  // Value limits in microseconds
  localparam logic [31:0] TPT_TIME_MAX = 32'h0393_8700;
  // Clock and tick
  localparam int TPT_CLK_MHZ = 10;
  localparam int TPT_TICK_US = 1;
  localparam int TPT_TICK_CYC = TPT_CLK_MHZ * TPT_TICK_US;
  // Trigger origin codes
  localparam logic [1:0] TPT_ORG_OFF = 2'h0;
  localparam logic [1:0] TPT_ORG_EXPO = 2'h1;
  localparam logic [1:0] TPT_ORG_READ = 2'h2;
  localparam logic [1:0] TPT_ORG_PIN = 2'h3;
  // Trigger condition codes
  localparam logic [1:0] TPT_RISE_MODE = 2'h0;
  localparam logic [1:0] TPT_FALL_MODE = 2'h1;
  localparam logic [1:0] TPT_HI_LEVEL_MODE = 2'h2;
  localparam logic [1:0] TPT_LO_LEVEL_MODE = 2'h3;
  // Output pin drive codes
  localparam logic [2:0] TPT_DRV_OFF = 3'h0;
  localparam logic [2:0] TPT_DRV_EXPO = 3'h1;
  localparam logic [2:0] TPT_DRV_READ = 3'h2;
  localparam logic [2:0] TPT_DRV_USER = 3'h3;
  localparam logic [2:0] TPT_DRV_TIMER = 3'h4;
  // Timer states
  typedef enum logic [2:0] {
    TPT_IDLE = 3'b001,
    TPT_WAIT = 3'b010,
    TPT_ACT = 3'b100
  } tpt_state_t;
endpackage

// *** core/tpt_sync.sv ***
// Three-stage input synchroniser with agreement filter for external pins.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tpt_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Shift chain; output changes once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        sync_out <= s3_q;
    end
  end
endmodule
`default_nettype wire

// *** core/tpt_top.sv ***
// Triggered pulse timer with output pin selection and AXI4-Lite registers.
// Assumes exposure and readout windows are on clk; the input pin is asynchronous.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tpt_top #(
  parameter int TICK_CYC = tpt_pkg::TPT_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic exposure_window,
  input wire logic readout_window,
  input wire logic external_input_pin,
  output logic pin_out,
  output logic pulse_timer_output,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [1:0] trig_origin_sel_q;
  logic [1:0] trig_condition_sel_q;
  logic [2:0] pin_drive_sel_q;
  logic pin_polarity_flip_q;
  logic user_level_q;
  logic [31:0] pulse_length_q;
  logic [31:0] start_wait_q;
  logic restart_cmd_q;
  logic [31:0] count_q;
  logic [7:0] tick_cnt_q;
  logic tick_q;
  logic src_q;
  tpt_pkg::tpt_state_t state_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic pin_sync;

  // Input pin crosses into the clock domain
  tpt_sync u_pin_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(external_input_pin),
    .sync_out(pin_sync)
  );

  // Source selection and trigger qualification
  wire src_now = (trig_origin_sel_q == tpt_pkg::TPT_ORG_EXPO) ? exposure_window :
                 (trig_origin_sel_q == tpt_pkg::TPT_ORG_READ) ? readout_window :
                 (trig_origin_sel_q == tpt_pkg::TPT_ORG_PIN) ? pin_sync : 1'b0;
  wire origin_on = (trig_origin_sel_q != tpt_pkg::TPT_ORG_OFF);
  wire level_mode = trig_condition_sel_q[1];
  wire rise_hit = src_now & ~src_q;
  wire fall_hit = ~src_now & src_q;
  wire src_active = (trig_condition_sel_q == tpt_pkg::TPT_LO_LEVEL_MODE) ? ~src_now : src_now;
  wire trig_hit = origin_on & ((trig_condition_sel_q == tpt_pkg::TPT_RISE_MODE) ? rise_hit :
                  (trig_condition_sel_q == tpt_pkg::TPT_FALL_MODE) ? fall_hit : src_active);
  wire [31:0] count_dec = count_q - 32'h0000_0001;
  wire count_done = (count_q == 32'h0000_0000);

  // Register bus decode
  // A channel counts only once its own handshake has happened
  wire aw_ok = aw_hold_q | (s_axi_awvalid & s_axi_awready);
  wire w_ok = w_hold_q | (s_axi_wvalid & s_axi_wready);
  wire [7:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire wr_go = aw_ok & w_ok & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & (wr_addr == tpt_pkg::TPT_CTRL_OFS);
  wire wr_pulse = wr_go & (wr_addr == tpt_pkg::TPT_PULSE_OFS);
  wire wr_wait = wr_go & (wr_addr == tpt_pkg::TPT_WAIT_OFS);
  wire wr_cmd = wr_go & (wr_addr == tpt_pkg::TPT_CMD_OFS) & wr_strb[0] & wr_data[0];
  wire wr_map = (wr_addr == tpt_pkg::TPT_CTRL_OFS) | (wr_addr == tpt_pkg::TPT_PULSE_OFS) |
                (wr_addr == tpt_pkg::TPT_WAIT_OFS) | (wr_addr == tpt_pkg::TPT_CMD_OFS) |
                (wr_addr == tpt_pkg::TPT_STAT_OFS);
  wire [31:0] ctrl_word = {19'h0, pin_polarity_flip_q, user_level_q, pin_drive_sel_q, 2'h0,
                           trig_condition_sel_q, 2'h0, trig_origin_sel_q};
  wire [31:0] stat_word = {27'h0, pulse_timer_output, pin_sync, state_q};
  wire [31:0] pulse_merge = {wr_strb[3] ? wr_data[31:24] : pulse_length_q[31:24],
                             wr_strb[2] ? wr_data[23:16] : pulse_length_q[23:16],
                             wr_strb[1] ? wr_data[15:8] : pulse_length_q[15:8],
                             wr_strb[0] ? wr_data[7:0] : pulse_length_q[7:0]};
  wire [31:0] wait_merge = {wr_strb[3] ? wr_data[31:24] : start_wait_q[31:24],
                            wr_strb[2] ? wr_data[23:16] : start_wait_q[23:16],
                            wr_strb[1] ? wr_data[15:8] : start_wait_q[15:8],
                            wr_strb[0] ? wr_data[7:0] : start_wait_q[7:0]};
  // Values are clamped into the allowed range
  wire [31:0] pulse_new = (pulse_merge == 32'h0) ? 32'h0000_0001 :
                          (pulse_merge > tpt_pkg::TPT_TIME_MAX) ? tpt_pkg::TPT_TIME_MAX : pulse_merge;
  wire [31:0] wait_new = (wait_merge > tpt_pkg::TPT_TIME_MAX) ? tpt_pkg::TPT_TIME_MAX : wait_merge;
  wire [31:0] rd_word = (s_axi_araddr == tpt_pkg::TPT_CTRL_OFS) ? ctrl_word :
                        (s_axi_araddr == tpt_pkg::TPT_PULSE_OFS) ? pulse_length_q :
                        (s_axi_araddr == tpt_pkg::TPT_WAIT_OFS) ? start_wait_q :
                        (s_axi_araddr == tpt_pkg::TPT_STAT_OFS) ? stat_word : 32'h0;
  wire rd_map = (s_axi_araddr == tpt_pkg::TPT_CTRL_OFS) | (s_axi_araddr == tpt_pkg::TPT_PULSE_OFS) |
                (s_axi_araddr == tpt_pkg::TPT_WAIT_OFS) | (s_axi_araddr == tpt_pkg::TPT_CMD_OFS) |
                (s_axi_araddr == tpt_pkg::TPT_STAT_OFS);
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

  // Pin source selection and polarity
  wire pin_src = (pin_drive_sel_q == tpt_pkg::TPT_DRV_EXPO) ? exposure_window :
                 (pin_drive_sel_q == tpt_pkg::TPT_DRV_READ) ? readout_window :
                 (pin_drive_sel_q == tpt_pkg::TPT_DRV_USER) ? user_level_q :
                 (pin_drive_sel_q == tpt_pkg::TPT_DRV_TIMER) ? pulse_timer_output : 1'b0;
  wire pin_next = pin_src ^ pin_polarity_flip_q;

  // Write address and data holding
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awready & s_axi_awvalid)
      begin
        aw_hold_q <= ~wr_go;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_hold_q <= 1'b0;
      if (s_axi_wready & s_axi_wvalid)
      begin
        w_hold_q <= ~wr_go;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_go)
        w_hold_q <= 1'b0;
    end
  end

  // Bus handshake outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_hold_q & ~(s_axi_awready & s_axi_awvalid) & ~s_axi_bvalid & ~wr_go;
      s_axi_wready <= ~w_hold_q & ~(s_axi_wready & s_axi_wvalid) & ~s_axi_bvalid & ~wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= rd_go & ~s_axi_arready;
      if (rd_go & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_origin_sel_q <= tpt_pkg::TPT_ORG_OFF;
      trig_condition_sel_q <= tpt_pkg::TPT_RISE_MODE;
      pin_drive_sel_q <= tpt_pkg::TPT_DRV_OFF;
      pin_polarity_flip_q <= 1'b0;
      user_level_q <= 1'b0;
      pulse_length_q <= tpt_pkg::TPT_PULSE_RST;
      start_wait_q <= tpt_pkg::TPT_WAIT_RST;
      restart_cmd_q <= 1'b0;
    end
    else if (ce)
    begin
      restart_cmd_q <= wr_cmd;
      if (wr_ctrl & wr_strb[0])
      begin
        trig_origin_sel_q <= wr_data[tpt_pkg::TPT_ORIGIN_POS +: 2];
        trig_condition_sel_q <= wr_data[tpt_pkg::TPT_COND_POS +: 2];
      end
      if (wr_ctrl & wr_strb[1])
      begin
        pin_drive_sel_q <= wr_data[tpt_pkg::TPT_DRIVE_POS +: 3];
        user_level_q <= wr_data[tpt_pkg::TPT_DRIVE_POS + 3];
        pin_polarity_flip_q <= wr_data[tpt_pkg::TPT_FLIP_POS];
      end
      if (wr_pulse)
        pulse_length_q <= pulse_new;
      if (wr_wait)
        start_wait_q <= wait_new;
    end
  end

  // Microsecond tick, restarted at each trigger and as the output rises, so the wait and the edge-mode pulse are whole microseconds
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      tick_q <= (tick_cnt_q == 8'(TICK_CYC - 2));
      if (state_q == tpt_pkg::TPT_IDLE || tick_cnt_q == 8'(TICK_CYC - 1)
          || (state_q == tpt_pkg::TPT_WAIT && count_done))
        tick_cnt_q <= 8'h00;
      else
        tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // Timer sequence: idle, start wait, active output
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= tpt_pkg::TPT_IDLE;
      count_q <= 32'h0;
      src_q <= 1'b0;
      pulse_timer_output <= 1'b0;
    end
    else if (ce)
    begin
      src_q <= src_now;
      if (restart_cmd_q || !origin_on)
      begin
        state_q <= tpt_pkg::TPT_IDLE;
        pulse_timer_output <= 1'b0;
      end
      else
      begin
        case (state_q)
          tpt_pkg::TPT_IDLE:
          begin
            if (trig_hit)
            begin
              state_q <= tpt_pkg::TPT_WAIT;
              count_q <= start_wait_q;
            end
          end
          tpt_pkg::TPT_WAIT:
          begin
            if (level_mode && !src_active)
              state_q <= tpt_pkg::TPT_IDLE;
            else if (count_done)
            begin
              state_q <= tpt_pkg::TPT_ACT;
              count_q <= pulse_length_q;
              pulse_timer_output <= 1'b1;
            end
            else if (tick_q)
              count_q <= count_dec;
          end
          tpt_pkg::TPT_ACT:
          begin
            if (level_mode ? !src_active : (count_q == 32'h0000_0001 && tick_q))
            begin
              state_q <= tpt_pkg::TPT_IDLE;
              pulse_timer_output <= 1'b0;
            end
            else if (tick_q && !level_mode)
              count_q <= count_dec;
          end
          default:
          begin
            state_q <= tpt_pkg::TPT_IDLE;
            pulse_timer_output <= 1'b0;
          end
        endcase
      end
    end
  end

  // Output pin register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_out <= 1'b0;
    else if (ce)
      pin_out <= pin_next;
  end

  chk_off_idle: assert property (@(posedge clk) disable iff (rst)
    ce && !origin_on |=> !pulse_timer_output) else $error("Timer active with origin off");
  chk_restart_abort: assert property (@(posedge clk) disable iff (rst)
    ce && restart_cmd_q |=> state_q == tpt_pkg::TPT_IDLE && !pulse_timer_output)
    else $error("Restart did not idle timer");
  chk_pin_timer: assert property (@(posedge clk) disable iff (rst)
    ce && pin_drive_sel_q == tpt_pkg::TPT_DRV_TIMER |=> pin_out == ($past(pulse_timer_output) ^ $past(pin_polarity_flip_q)))
    else $error("Pin does not follow timer");
  chk_pin_off: assert property (@(posedge clk) disable iff (rst)
    ce && pin_drive_sel_q == tpt_pkg::TPT_DRV_OFF |=> pin_out == $past(pin_polarity_flip_q))
    else $error("Pin off level wrong");
  chk_rise_start: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == tpt_pkg::TPT_IDLE && origin_on && !restart_cmd_q
    && trig_condition_sel_q == tpt_pkg::TPT_RISE_MODE && rise_hit |=> state_q == tpt_pkg::TPT_WAIT)
    else $error("Rising edge missed");
  chk_fall_start: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == tpt_pkg::TPT_IDLE && origin_on && !restart_cmd_q
    && trig_condition_sel_q == tpt_pkg::TPT_FALL_MODE && fall_hit |=> state_q == tpt_pkg::TPT_WAIT)
    else $error("Falling edge missed");
  chk_level_drop: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == tpt_pkg::TPT_ACT && level_mode && !src_active |=> !pulse_timer_output)
    else $error("Level output outlived source");
  chk_wait_order: assert property (@(posedge clk) disable iff (rst)
    $rose(pulse_timer_output) |-> $past(state_q) == tpt_pkg::TPT_WAIT && $past(count_done))
    else $error("Output rose without finished wait");
  chk_tick_rate: assert property (@(posedge clk) disable iff (rst)
    ce && tick_q |=> !tick_q) else $error("Tick longer than one cycle");
endmodule
`default_nettype wire

// *** sim/tpt_equip.sv ***
// Model of the equipment wired to the camera: drives its input pin, times its output line.
// Assumes trig_req comes from the bench on clk; the pin itself moves off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module tpt_equip (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_out,
  input wire logic trig_req,
  output var logic external_input_pin,
  output var int hi_width
);
  int cnt;
  // Pin follows the request with a skew unrelated to clk, so the synchroniser is exercised
  initial external_input_pin = 1'b0;
  always @(trig_req)
    external_input_pin <= #37 trig_req;
  // Length in cycles of the last high pulse seen on the output line
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      hi_width <= 0;
    end
    else if (pin_out)
      cnt <= cnt + 1;
    else if (cnt != 0)
    begin
      hi_width <= cnt;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// *** sim/tpt_top_bench.sv ***
// Self-checking bench for the triggered pulse timer: AXI4-Lite tasks and timed trials.
// Assumes a 10 MHz clk and a shortened microsecond tick of T cycles.
`timescale 1ns/1ps
`default_nettype none
module tpt_top_bench;
  localparam int T = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic exposure_window = 1'b0;
  logic readout_window = 1'b0;
  logic trig_req = 1'b0;
  logic external_input_pin, pin_out, pulse_timer_output;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int hw;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  tpt_top #(.TICK_CYC(T)) tpt_top_i (.clk(clk), .rst(rst), .ce(ce), .exposure_window(exposure_window),
    .readout_window(readout_window), .external_input_pin(external_input_pin), .pin_out(pin_out),
    .pulse_timer_output(pulse_timer_output), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  tpt_equip tpt_equip_i (.clk(clk), .rst(rst), .pin_out(pin_out), .trig_req(trig_req),
    .external_input_pin(external_input_pin), .hi_width(hw));

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk({31'h0, n < 100}, 32'h1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk({31'h0, n < 100}, 32'h1);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] o, input logic [1:0] c, input logic [2:0] dv,
    input logic u, input logic f);
    return {19'h0, f, u, dv, 2'h0, c, 2'h0, o};
  endfunction

  task automatic set_src(input logic [1:0] o, input logic v);
    @(posedge clk);
    case (o)
      2'h1: exposure_window <= v;
      2'h2: readout_window <= v;
      default: trig_req <= v;
    endcase
  endtask

  task automatic rise_wait(output int d);
    d = 0;
    do
    begin
      @(posedge clk);
      d++;
    end
    while (pulse_timer_output !== 1'b1 && d < 500);
  endtask

  task automatic high_len(output int w);
    w = 0;
    while (pulse_timer_output === 1'b1 && w < 2000)
    begin
      @(posedge clk);
      w++;
    end
  endtask

  // Arm with origin off, park source idle, configure, then hold it active for 'hold' cycles
  task automatic trial(input logic [1:0] o, input logic [1:0] c, input int len, input int w, input int hold);
    int d;
    int wd;
    int ex;
    ex = (o == 2'h3) ? 3 : 0;
    wr(8'h00, 32'h0, 2'h0);
    set_src(o, c[0]);
    wr(tpt_pkg::TPT_PULSE_OFS, 32'(len), 2'h0);
    wr(tpt_pkg::TPT_WAIT_OFS, 32'(w), 2'h0);
    wr(8'h00, ctl(o, c, 3'h4, 1'b0, 1'b0), 2'h0);
    set_src(o, ~c[0]);
    fork
      begin
        rise_wait(d);
        high_len(wd);
      end
      begin
        repeat (hold) @(posedge clk);
        set_src(o, c[0]);
      end
    join
    repeat (4) @(posedge clk);
    in_range(d, w * T + 2 + ex, w * T + 6 + ex + ex);
    if (c[1] == 1'b0)
      chk(wd, len * T);
    else
      in_range(wd, hold - w * T - 8, hold - w * T);
    chk(hw, wd);
  endtask

  initial
  begin
    int d;
    int wd;
    int hi;
    logic [2:0] dv;
    logic f;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, tpt_pkg::TPT_PULSE_RST, 2'h0);
    rd(8'h08, tpt_pkg::TPT_WAIT_RST, 2'h0);
    rd(8'h10, 32'h1, 2'h0);
    rd(8'h14, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    wr(8'h04, 32'h0, 2'h0);
    rd(8'h04, 32'h1, 2'h0);
    wr(8'h04, 32'hffff_ffff, 2'h0);
    rd(8'h04, tpt_pkg::TPT_TIME_MAX, 2'h0);
    wr(8'h08, 32'hffff_ffff, 2'h0);
    rd(8'h08, tpt_pkg::TPT_TIME_MAX, 2'h0);
    rd(8'h0c, 32'h0, 2'h0);
    $display("test registers done");
    trial(2'h1, 2'h0, 3, 2, 3);
    trial(2'h2, 2'h1, 1, 0, 40);
    trial(2'h3, 2'h0, 2, 1, 5);
    trial(2'h1, 2'h1, 4, 3, 2);
    $display("test edge modes done");
    trial(2'h3, 2'h2, 1, 1, 40);
    trial(2'h2, 2'h3, 1, 1, 40);
    $display("test level modes done");
    wr(8'h00, ctl(2'h0, 2'h0, 3'h4, 1'b0, 1'b0), 2'h0);
    set_src(2'h1, 1'b1);
    hi = 0;
    repeat (30)
    begin
      @(posedge clk);
      if (pulse_timer_output !== 1'b0)
        hi++;
    end
    set_src(2'h1, 1'b0);
    chk(hi, 0);
    rd(8'h10, 32'h1, 2'h0);
    $display("test origin off done");
    wr(8'h04, 32'd100, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h00, ctl(2'h1, 2'h0, 3'h4, 1'b0, 1'b0), 2'h0);
    set_src(2'h1, 1'b1);
    rise_wait(d);
    wr(tpt_pkg::TPT_CMD_OFS, 32'h1, 2'h0);
    repeat (3) @(posedge clk);
    chk(pulse_timer_output, 32'h0);
    rd(8'h10, 32'h1, 2'h0);
    wr(8'h04, 32'h2, 2'h0);
    set_src(2'h1, 1'b0);
    set_src(2'h1, 1'b1);
    rise_wait(d);
    // Freeze the block for five cycles in mid pulse: the pulse must stretch by exactly that much
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    high_len(wd);
    chk(wd, 2 * T);
    repeat (3) @(posedge clk);
    chk(hw, 2 * T + 5);
    $display("test restart done");
    wr(8'h00, 32'h0, 2'h0);
    // Exposure stays high, readout goes low, so the two window sources give different levels
    set_src(2'h2, 1'b0);
    for (int i = 0; i < 10; i++)
    begin
      dv = 3'(i % 5);
      f = (i >= 5);
      wr(8'h00, ctl(2'h0, 2'h0, dv, 1'b1, f), 2'h0);
      repeat (3) @(posedge clk);
      chk(pin_out, {31'h0, (dv == 3'h1 || dv == 3'h3) ^ f});
    end
    $display("test pin select done");
    wrap_up();
  end
endmodule
`default_nettype wire
